// ===== src/ref_select_cfg.svh
// Register offsets, field positions and reset values for the channel control block
`ifndef REF_SELECT_CFG_SVH
`define REF_SELECT_CFG_SVH

// Printed offsets are not multiples of four: they are register indices
`define IDX_CHAN2_MODE      8'h3D
`define IDX_CHAN2_MASKS     8'h3E
`define IDX_CHAN3_LOOP      8'h3F
`define IDX_CHAN3_PRIO_UP   8'h40
`define IDX_CHAN3_PRIO_LO   8'h41
`define IDX_CHAN3_MODE      8'h42
`define IDX_CHAN2_LOOP      8'h3A
`define IDX_CHAN2_PRIO_UP   8'h3B
`define IDX_CHAN2_PRIO_LO   8'h3C
`define IDX_CHAN3_MASKS     8'h43
`define IDX_FAIL_STATUS     8'h50

// Reset values
`define RST_MODE            8'h03
`define RST_MASKS           8'h87
`define RST_LOOP            8'h0D
`define RST_PRIO_UP         8'h32
`define RST_PRIO_LO         8'h10

// Field positions
`define MODE_LSB            0
`define FB_EN_BIT           5
`define REFSEL_LSB          6
`define HOLD_GATE_LSB       0
`define SWITCH_GATE_LSB     4
`define RANGE_LSB           0
`define SLOPE_LSB           2
`define ALIGN_BIT           4
`define BW_LSB              5
`define RANK_LO_LSB         0
`define RANK_HI_LSB         4

// Rank that removes a reference from selection
`define RANK_DISABLED       3'h7
// Bandwidth code that is reserved
`define BW_RESERVED         3'h7
// Slope code whose meaning is undefined
`define SLOPE_UNDEFINED     2'h3

`endif

// ===== src/ref_select_pkg.sv
// Types shared by the channel control block
package ref_select_pkg;
    // Operating mode codes of a channel
    typedef enum logic [1:0] {
        MODE_FREERUN,
        MODE_HOLDOVER,
        MODE_FORCED,
        MODE_AUTO
    } op_mode_e;

    // Loop state that a channel reports
    typedef enum logic [1:0] {
        ST_FREERUN,
        ST_HOLDOVER,
        ST_LOCKED
    } loop_state_e;

    typedef logic [1:0] ref_index_t;
    typedef logic [2:0] rank_t;
endpackage

// ===== src/dpll_reference_mode_select.sv
// Mode, reference selection and loop settings for channels 2 and 3, AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ref_select_cfg.svh"
// Overview of operation
// - Mode codes: freerun, holdover, forced, automatic
// - Automatic picks reference by availability and rank
// - Automatic holds over only when none available
// - Forced lock never switches; holds over on hold-gated failure only
// - Forced holdover ignores references, keeps last
// - Freerun runs only from local oscillator
// - Feedback enable applies external phase compensation
// - Single feedback measurement shared by enabled channels
// - Reference field reads selection in automatic
// - Reference field selects forced reference
// - Reference field ignored in freerun, holdover
// - Holdover gate bits let failures cause holdover
// - Switch gate bits let failures cause switching
// - Capture range code drives loop range
// - Slope limit code drives phase slope
// - Phase align bit aligns output to input
// - Bandwidth code selects loop filter bandwidth
// - Rank per reference, zero best, seven excluded
// - Revertive between different ranks
// - Non-revertive among equal ranks
// - Ranks packed two per register
module dpll_reference_mode_select (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [3:0]  ref_signal_loss_failure,
    input  wire logic [3:0]  ref_single_cycle_failure,
    input  wire logic [3:0]  ref_coarse_freq_failure,
    input  wire logic [3:0]  ref_guard_timer_failure,
    output logic [1:0]       chan2_state,
    output logic [1:0]       chan3_state,
    output logic [1:0]       chan2_active_ref,
    output logic [1:0]       chan3_active_ref,
    output logic             chan2_use_local_oscillator_input,
    output logic             chan3_use_local_oscillator_input,
    output logic             chan2_apply_feedback,
    output logic             chan3_apply_feedback,
    output logic [7:0]       chan2_loop_settings,
    output logic [7:0]       chan3_loop_settings
);

    // Register storage; index 0 is channel 2, index 1 is channel 3
    logic [7:0] mode_reg   [2];   // Mode, feedback enable, reference field
    logic [7:0] mask_reg   [2];   // Holdover and switch gates
    logic [7:0] loop_reg   [2];   // Range, slope, align, bandwidth
    logic [7:0] prio_up    [2];   // Ranks of references 2 and 3
    logic [7:0] prio_lo    [2];   // Ranks of references 0 and 1
    logic [1:0] sel_ref    [2];   // Reference the channel tracks
    logic [1:0] st         [2];   // Loop state per channel
    logic [1:0] next_sel   [2];
    logic [1:0] next_st    [2];

    // Data-phase capture of the address phase
    logic       dp_write;
    logic       dp_read;
    logic [7:0] dp_index;

    // Failure inputs grouped per reference as {guard, coarse, single, loss}
    logic [3:0] fail_vec [4];

    // Address phase accepted when selected, transferring and bus ready
    wire        take     = hsel & htrans[1] & hready;
    // Index from the aligned byte address
    wire [7:0]  a_index  = haddr[9:2];

    // Rank of reference r taken from the packed pair registers
    function automatic ref_select_pkg::rank_t rank_of(input logic [7:0] up,
                                                      input logic [7:0] lo,
                                                      input logic [1:0] r);
        case (r)
            2'h0:    rank_of = lo[`RANK_LO_LSB +: 3];
            2'h1:    rank_of = lo[`RANK_HI_LSB +: 3];
            2'h2:    rank_of = up[`RANK_LO_LSB +: 3];
            default: rank_of = up[`RANK_HI_LSB +: 3];
        endcase
    endfunction

    // Regroup failures per reference
    generate
        for (genvar r = 0; r < 4; r++) begin : g_fail
            assign fail_vec[r] = {ref_guard_timer_failure[r], ref_coarse_freq_failure[r],
                                  ref_single_cycle_failure[r], ref_signal_loss_failure[r]};
        end
    endgenerate

    // Per-channel selection logic
    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            logic [3:0] hold_fail;     // Failures allowed to force holdover
            logic [3:0] switch_fail;   // Failures allowed to trigger a switch
            logic [3:0] usable;        // Available and not excluded by rank
            logic [1:0] best;          // Usable reference of lowest rank
            logic       any_usable;
            ref_select_pkg::rank_t best_rank;
            ref_select_pkg::rank_t cur_rank;
            ref_select_pkg::op_mode_e mode;
            wire [3:0] hgate = mask_reg[c][`HOLD_GATE_LSB +: 4];
            wire [3:0] sgate = mask_reg[c][`SWITCH_GATE_LSB +: 4];

            assign mode = ref_select_pkg::op_mode_e'(mode_reg[c][`MODE_LSB +: 2]);

            for (genvar r = 0; r < 4; r++) begin : g_ref
                assign hold_fail[r]   = |(fail_vec[r] & hgate);
                assign switch_fail[r] = |(fail_vec[r] & sgate);
                assign usable[r] = ~hold_fail[r] & ~switch_fail[r] &
                    (rank_of(prio_up[c], prio_lo[c], 2'(r)) != `RANK_DISABLED);
            end

            // Lowest rank wins; first index on ties
            always_comb begin
                best       = 2'h0;
                best_rank  = `RANK_DISABLED;
                any_usable = 1'b0;
                for (int r = 0; r < 4; r++) begin
                    if (usable[r] && (!any_usable ||
                        rank_of(prio_up[c], prio_lo[c], 2'(r)) < best_rank)) begin
                        best       = 2'(r);
                        best_rank  = rank_of(prio_up[c], prio_lo[c], 2'(r));
                        any_usable = 1'b1;
                    end
                end
            end

            assign cur_rank = rank_of(prio_up[c], prio_lo[c], sel_ref[c]);

            // Next selection and loop state per mode
            always_comb begin
                next_sel[c] = sel_ref[c];
                next_st[c]  = st[c];
                case (mode)
                    ref_select_pkg::MODE_FREERUN: begin
                        next_st[c] = ref_select_pkg::ST_FREERUN;
                    end
                    ref_select_pkg::MODE_HOLDOVER: begin
                        next_st[c] = ref_select_pkg::ST_HOLDOVER;
                    end
                    ref_select_pkg::MODE_FORCED: begin
                        next_sel[c] = mode_reg[c][`REFSEL_LSB +: 2];
                        if (hold_fail[mode_reg[c][`REFSEL_LSB +: 2]])
                            next_st[c] = ref_select_pkg::ST_HOLDOVER;
                        else
                            next_st[c] = ref_select_pkg::ST_LOCKED;
                    end
                    default: begin
                        if (!any_usable) begin
                            next_st[c] = ref_select_pkg::ST_HOLDOVER;
                        end else begin
                            next_st[c] = ref_select_pkg::ST_LOCKED;
                            // stay on equal rank while usable
                            if (!usable[sel_ref[c]] || best_rank < cur_rank ||
                                st[c] != ref_select_pkg::ST_LOCKED)
                                next_sel[c] = best;
                        end
                    end
                endcase
            end
        end
    endgenerate

    // Read-back value of the addressed register
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (dp_index == `IDX_CHAN2_MODE)
            rd_byte = mode_reg[0];
        else if (dp_index == `IDX_CHAN3_MODE)
            rd_byte = mode_reg[1];
        else if (dp_index == `IDX_CHAN2_MASKS)
            rd_byte = mask_reg[0];
        else if (dp_index == `IDX_CHAN3_MASKS)
            rd_byte = mask_reg[1];
        else if (dp_index == `IDX_CHAN2_LOOP)
            rd_byte = loop_reg[0];
        else if (dp_index == `IDX_CHAN3_LOOP)
            rd_byte = loop_reg[1];
        else if (dp_index == `IDX_CHAN2_PRIO_UP)
            rd_byte = prio_up[0];
        else if (dp_index == `IDX_CHAN3_PRIO_UP)
            rd_byte = prio_up[1];
        else if (dp_index == `IDX_CHAN2_PRIO_LO)
            rd_byte = prio_lo[0];
        else if (dp_index == `IDX_CHAN3_PRIO_LO)
            rd_byte = prio_lo[1];
        else if (dp_index == `IDX_FAIL_STATUS)
            rd_byte = {2'h0, st[1], 2'h0, st[0]};
        else
            rd_hit = 1'b0;
    end

    // Bus capture; a read costs one wait state, the response is always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write  <= 1'b0;
            dp_read   <= 1'b0;
            dp_index  <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dp_write  <= take & hwrite;
            dp_read   <= take & ~hwrite;
            if (take)
                dp_index <= a_index;
            // Read data is loaded at the end of the wait cycle
            hrdata    <= (dp_read & rd_hit) ? {24'h0, rd_byte} : 32'h0000_0000;
            // Ready drops for one cycle after a read address phase, so the
            // registered data already stands when the data phase completes
            hreadyout <= ~(take & ~hwrite);
            hresp     <= 1'b0;
        end
    end

    // Register writes and channel state; writes land in the data phase
    generate
        for (genvar c = 0; c < 2; c++) begin : g_regs
            wire [7:0] i_mode = c ? `IDX_CHAN3_MODE    : `IDX_CHAN2_MODE;
            wire [7:0] i_mask = c ? `IDX_CHAN3_MASKS   : `IDX_CHAN2_MASKS;
            wire [7:0] i_loop = c ? `IDX_CHAN3_LOOP    : `IDX_CHAN2_LOOP;
            wire [7:0] i_up   = c ? `IDX_CHAN3_PRIO_UP : `IDX_CHAN2_PRIO_UP;
            wire [7:0] i_lo   = c ? `IDX_CHAN3_PRIO_LO : `IDX_CHAN2_PRIO_LO;
            wire       auto   = mode_reg[c][1:0] == 2'h3;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mode_reg[c] <= `RST_MODE;
                    mask_reg[c] <= `RST_MASKS;
                    loop_reg[c] <= `RST_LOOP;
                    prio_up[c]  <= `RST_PRIO_UP;
                    prio_lo[c]  <= `RST_PRIO_LO;
                    sel_ref[c]  <= 2'h0;
                    st[c]       <= 2'h0;
                end else begin
                    sel_ref[c] <= next_sel[c];
                    st[c]      <= next_st[c];
                    if (dp_write && dp_index == i_mode) begin
                        // Reserved bits 4:2 kept at zero
                        mode_reg[c] <= {hwdata[7:5], 3'h0, hwdata[1:0]};
                    end else if (auto) begin
                        mode_reg[c][`REFSEL_LSB +: 2] <= next_sel[c];
                    end
                    // software keeps the guard-only pattern out
                    if (dp_write && dp_index == i_mask)
                        mask_reg[c] <= hwdata[7:0];
                    if (dp_write && dp_index == i_loop)
                        loop_reg[c] <= hwdata[7:0];
                    if (dp_write && dp_index == i_up)
                        prio_up[c] <= hwdata[7:0] & 8'h77;
                    if (dp_write && dp_index == i_lo)
                        prio_lo[c] <= hwdata[7:0] & 8'h77;
                end
            end
        end
    endgenerate

    // Outputs to the loop engines, all registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan2_state                      <= 2'h0;
            chan3_state                      <= 2'h0;
            chan2_active_ref                 <= 2'h0;
            chan3_active_ref                 <= 2'h0;
            // Reset loop state is freerun, so the oscillator flag starts high
            chan2_use_local_oscillator_input <= 1'b1;
            chan3_use_local_oscillator_input <= 1'b1;
            chan2_apply_feedback             <= 1'b0;
            chan3_apply_feedback             <= 1'b0;
            chan2_loop_settings              <= `RST_LOOP;
            chan3_loop_settings              <= `RST_LOOP;
        end else begin
            chan2_state      <= st[0];
            chan3_state      <= st[1];
            chan2_active_ref <= sel_ref[0];
            chan3_active_ref <= sel_ref[1];
            chan2_use_local_oscillator_input <= st[0] == ref_select_pkg::ST_FREERUN;
            chan3_use_local_oscillator_input <= st[1] == ref_select_pkg::ST_FREERUN;
            chan2_apply_feedback <= mode_reg[0][`FB_EN_BIT];
            chan3_apply_feedback <= mode_reg[1][`FB_EN_BIT];
            // loop fields passed whole to the loop
            chan2_loop_settings <= loop_reg[0];
            chan3_loop_settings <= loop_reg[1];
        end
    end

endmodule

// ===== verification/dpll_select_assertions.sv
// Concurrent port checks for the channel control block
`timescale 1ns/1ps
module dpll_select_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  chan2_state,
    input wire logic [1:0]  chan3_state,
    input wire logic [1:0]  chan3_active_ref,
    input wire logic        chan2_use_local_oscillator_input,
    input wire logic        chan3_use_local_oscillator_input,
    input wire logic        chan2_apply_feedback,
    input wire logic [7:0]  chan3_loop_settings
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Write address phase taken at byte address a
    sequence s_wr(a);
        hsel && htrans[1] && hready && hwrite && haddr == a;
    endsequence
    // Loop register write lands on the settings output
    property p_loop;
        logic [7:0] d;
        s_wr(32'h0FC) ##1 (1, d = hwdata[7:0]) |-> ##[1:2] chan3_loop_settings == d;
    endproperty
    // Feedback enable follows bit 5 of the written mode word
    property p_fb;
        logic d;
        s_wr(32'h0F4) ##1 (1, d = hwdata[5]) |-> ##[1:2] chan2_apply_feedback == d;
    endproperty
    a_read_wait: assert property (hreadyout != $past(hsel & htrans[1] & hready & ~hwrite))
        else $error("ready does not follow the read wait state");
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
    a_osc3_freerun: assert property (chan3_use_local_oscillator_input == (chan3_state == 2'h0))
        else $error("chan3 oscillator use does not match freerun");
    a_osc2_freerun: assert property (chan2_use_local_oscillator_input == (chan2_state == 2'h0))
        else $error("chan2 oscillator use does not match freerun");
    a_hold_keeps_ref: assert property ((chan3_state == 2'h1 && $past(chan3_state) == 2'h1) |-> $stable(chan3_active_ref))
        else $error("reference moved during holdover");
    a_freerun_entry: assert property (s_wr(32'h108) ##1 hwdata[1:0] == 2'h0 |-> ##[1:3] chan3_state == 2'h0)
        else $error("freerun code not obeyed");
    a_holdover_entry: assert property (s_wr(32'h108) ##1 hwdata[1:0] == 2'h1 |-> ##[1:3] chan3_state == 2'h1)
        else $error("forced holdover code not obeyed");
    a_loop_follow: assert property (p_loop)
        else $error("loop settings differ from written word");
    a_fb_follow: assert property (p_fb)
        else $error("feedback enable differs from written bit");
    a_state_legal: assert property (chan2_state != 2'h3 && chan3_state != 2'h3)
        else $error("undefined loop state");
endmodule
bind dpll_reference_mode_select dpll_select_checker u_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .chan2_state, .chan3_state,
    .chan3_active_ref, .chan2_use_local_oscillator_input, .chan3_use_local_oscillator_input,
    .chan2_apply_feedback, .chan3_loop_settings);

// ===== verification/tb_top.sv
// Self-checking bench for the channel control block
`timescale 1ns/1ps
module tb_top;
    logic        hclk;           // 250 MHz bus clock
    logic        hresetn;        // Active-low reset
    logic        hsel;           // Slave select
    logic [31:0] haddr;          // Byte address, four times the index
    logic [1:0]  htrans;         // Transfer type
    logic        hwrite;         // Write strobe
    logic [2:0]  hsize;          // Always a whole word
    logic [31:0] hwdata;         // Write data
    logic [31:0] hrdata;         // Read data
    logic        hreadyout;      // Slave ready, also the bus ready
    logic        hresp;          // Response code
    logic [3:0]  fail_kind [4];  // Loss, single-cycle, coarse, guard, per reference
    logic [1:0]  st2;            // Channel 2 loop state
    logic [1:0]  st3;            // Channel 3 loop state
    logic [1:0]  ref2;           // Channel 2 tracked reference
    logic [1:0]  ref3;           // Channel 3 tracked reference
    logic        osc2;           // Channel 2 local oscillator use
    logic        osc3;           // Channel 3 local oscillator use
    logic        fb2;            // Channel 2 feedback compensation
    logic        fb3;            // Channel 3 feedback compensation
    logic [7:0]  loop2;          // Channel 2 loop settings
    logic [7:0]  loop3;          // Channel 3 loop settings
    logic [31:0] rd;             // Last read word
    int          fail_count;     // Mismatches
    int          checks;         // Comparisons
    int          cycles;         // Hang guard
    logic [7:0]  rst_idx [10] = '{8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E,
                                  8'h3F, 8'h40, 8'h41, 8'h42, 8'h43};
    logic [7:0]  rst_val [10] = '{8'h0D, 8'h32, 8'h10, 8'h03, 8'h87,
                                  8'h0D, 8'h32, 8'h10, 8'h03, 8'h87};

    dpll_reference_mode_select u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ref_signal_loss_failure(fail_kind[0]), .ref_single_cycle_failure(fail_kind[1]),
        .ref_coarse_freq_failure(fail_kind[2]), .ref_guard_timer_failure(fail_kind[3]),
        .chan2_state(st2), .chan3_state(st3), .chan2_active_ref(ref2),
        .chan3_active_ref(ref3), .chan2_use_local_oscillator_input(osc2),
        .chan3_use_local_oscillator_input(osc3), .chan2_apply_feedback(fb2),
        .chan3_apply_feedback(fb3), .chan2_loop_settings(loop2), .chan3_loop_settings(loop3));

    // Free-running clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Cuts a hang short; the whole run needs about four hundred cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One word transfer; read data is taken at the edge that ends the data phase
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h000000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, {24'h000000, d});
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 32'h00000000);
        check("register", rd, {24'h000000, exp});
    endtask

    // Lets mode and failure changes reach the state outputs
    task automatic settle;
        repeat (6) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic setf(input int k, input logic [3:0] v);
        @(posedge hclk);
        fail_kind[k] <= v;
        settle();
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        fail_kind = '{default: 4'h0};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        foreach (rst_idx[i]) rdchk(rst_idx[i], rst_val[i]);
        wr(8'h3F, 8'hA5);
        rdchk(8'h3F, 8'hA5);
        check("loop3", {24'h0, loop3}, 32'hA5);
        wr(8'h3A, 8'h5A);
        rdchk(8'h3A, 8'h5A);
        check("loop2", {24'h0, loop2}, 32'h5A);
        // Reserved bits of the rank word read as zero
        wr(8'h40, 8'hFF);
        rdchk(8'h40, 8'h77);
        wr(8'h40, 8'h32);
        // Freerun with a reference code present
        wr(8'h42, 8'hC0);
        settle();
        check("st3", {30'h0, st3}, 32'h0);
        check("osc3", {31'h0, osc3}, 32'h1);
        wr(8'h42, 8'h41);
        settle();
        check("st3", {30'h0, st3}, 32'h1);
        // Every forced reference code
        for (int r = 0; r < 4; r++) begin
            wr(8'h42, {r[1:0], 6'h02});
            settle();
            check("ref3", {30'h0, ref3}, r);
            check("st3", {30'h0, st3}, 32'h2);
        end
        // Forced reference fails while others stay good
        setf(0, 4'h8);
        check("st3", {30'h0, st3}, 32'h1);
        check("ref3", {30'h0, ref3}, 32'h3);
        setf(0, 4'h0);
        // no gate word written here has the guard-only holdover pattern
        wr(8'h43, 8'h00);
        setf(0, 4'h8);
        check("st3", {30'h0, st3}, 32'h2);
        setf(0, 4'h0);
        wr(8'h43, 8'h87);
        // Automatic: each failure kind drives the channel off reference 0 and back
        wr(8'h42, 8'h03);
        settle();
        for (int k = 0; k < 4; k++) begin
            setf(k, 4'h1);
            check("ref3", {30'h0, ref3}, 32'h1);
            setf(k, 4'h0);
            check("ref3", {30'h0, ref3}, 32'h0);
        end
        setf(0, 4'hF);
        check("st3", {30'h0, st3}, 32'h1);
        setf(0, 4'h0);
        // Switch gate for loss only
        wr(8'h43, 8'h10);
        setf(0, 4'h1);
        check("ref3", {30'h0, ref3}, 32'h1);
        rdchk(8'h42, 8'h43);
        setf(0, 4'h0);
        wr(8'h43, 8'h87);
        // Excluded rank, then equal ranks, then a better rank again
        wr(8'h41, 8'h17);
        settle();
        check("ref3", {30'h0, ref3}, 32'h1);
        wr(8'h41, 8'h00);
        settle();
        check("ref3", {30'h0, ref3}, 32'h1);
        wr(8'h41, 8'h10);
        settle();
        check("ref3", {30'h0, ref3}, 32'h0);
        // Shared feedback on one channel only
        wr(8'h3D, 8'h23);
        settle();
        check("fb", {30'h0, fb2, fb3}, 32'h2);
        wr(8'h3D, 8'hC2);
        settle();
        check("ch2", {28'h0, st2, ref2}, 32'hB);
        check("fb2", {31'h0, fb2}, 32'h0);
        // Both channels locked in the state readback word
        rdchk(8'h50, 8'h22);
        wr(8'h3D, 8'h00);
        settle();
        check("osc2", {31'h0, osc2}, 32'h1);
        check("st2", {30'h0, st2}, 32'h0);
        // Unmapped place ignores writes and reads zero
        wr(8'h20, 8'h55);
        rdchk(8'h20, 8'h00);
        give_verdict();
    end
endmodule
